// >>> logic/srs_pkg.sv
// package: constants and types of the system reset sequencer
package srs_pkg;
  localparam int unsigned SEQ_CYCLES = 516;
  localparam int unsigned SEQ_CNT_W = 10;
  localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = 10'(SEQ_CYCLES - 1);
  localparam int unsigned WDT_PRESC = 2;
  localparam int unsigned WDT_W = 16;
  localparam int unsigned WDT_OVF_CYCLES = WDT_PRESC * (1 << WDT_W);
  localparam logic [7:0] WDT_RELOAD_RST = 8'h00;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RST_FILTER_NS = 100;
  localparam int unsigned RST_FILTER_CYC = (RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RST_FILTER_CNT = 2'(RST_FILTER_CYC);
  // apb map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CMD = 12'h008;
  localparam logic [11:0] REG_WDT = 12'h00C;
  localparam logic [11:0] REG_CFG = 12'h010;
  // ctrl bits
  localparam int unsigned CTRL_BDRST = 0;
  localparam int unsigned CTRL_PLLSEL = 1;
  // status bits
  localparam int unsigned ST_SHORT_HW_RESET_FLAG = 0;
  localparam int unsigned ST_LONG_HW_RESET_FLAG = 1;
  localparam int unsigned ST_WATCHDOG_RESET_FLAG = 2;
  localparam int unsigned ST_END_OF_INIT_INSTR = 3;
  localparam int unsigned ST_WDTDIS = 4;
  localparam int unsigned ST_BOOT = 5;
  localparam int unsigned ST_EXTSTART = 6;
  localparam int unsigned ST_ADAPT = 7;
  // cmd bits
  localparam int unsigned CMD_SOFTWARE_RESET_INSTR = 0;
  localparam int unsigned CMD_END_OF_INIT_INSTR = 1;
  localparam int unsigned CMD_SERVICE_WATCHDOG_INSTR = 2;
  localparam int unsigned CMD_DISABLE_WATCHDOG_INSTR = 3;
  localparam int unsigned CFG_W = 16;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
  typedef enum logic [3:0] {
    SRS_RUN = 4'b0001,
    SRS_BUSWAIT = 4'b0010,
    SRS_SEQ = 4'b0100,
    SRS_HOLD = 4'b1000
  } srs_state_t;
  typedef enum logic [1:0] {
    SRC_HW = 2'h0,
    SRC_SW = 2'h1,
    SRC_WDT = 2'h2
  } srs_src_t;
endpackage

// >>> logic/srs_system_reset_sequencer.sv
// system reset sequencer: reset sources, 516-cycle sequence, config latch, watchdog, apb registers
module srs_system_reset_sequencer
  import srs_pkg::*;
#(
  parameter int unsigned WDT_OVF = WDT_OVF_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset pins
  input wire logic reset_input_pin_i,
  output logic reset_input_pin_o,
  output logic reset_input_pin_oe_n,
  output logic reset_output_pin_n,
  // configuration inputs
  input wire logic [CFG_W-1:0] config_port,
  input wire logic rd_n_pin,
  input wire logic ale_pin,
  input wire logic ext_start_n,
  input wire logic adapt_mode_select,
  input wire logic pll_locked,
  // external bus cycle state
  input wire logic bus_cycle_active,
  input wire logic bus_uses_ready,
  input wire logic bus_ready_sampled,
  input wire logic bus_ready_n,
  // control towards the core
  output logic sys_reset,
  output logic hold_cancel,
  output logic bus_abort,
  output logic pins_tristate,
  output logic strobes_inactive,
  output logic cpu_run,
  output logic boot_mode,
  output logic [CFG_W-1:0] latched_cfg
);
  srs_state_t state_q, state_d;
  srs_src_t src_q;
  logic [SEQ_CNT_W-1:0] seq_cnt_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic [1:0] filt_q;
  logic pin_low;
  logic bdrst_q, pllsel_q, end_of_init_instr_q, wdt_dis_q, wdt_srv_seen_q;
  logic short_hw_reset_flag_q, long_hw_reset_flag_q, watchdog_reset_flag_q, adapt_q, boot_q, ext_q, strobe_q;
  logic [16:0] wdt_cnt_q;
  logic [CFG_W-1:0] cfg_q;
  logic rst_src_hw, rst_src_sw, rst_src_wdt, any_src;
  logic wr_en, rd_en, wr_ctrl, wr_cmd, cmd_software_reset_instr, cmd_end_of_init_instr, cmd_srv, cmd_dis;
  logic bus_done, wdt_ovf, in_reset, seq_end, release_ok;
  // bidirectional mode is frozen when a reset starts, since that reset clears the enable itself
  logic bd_q;

  // the first flop is only read by the second
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= reset_input_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // filter: pin must read low for the filter time before it counts as latched low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      filt_q <= 2'h0;
    end else if (pin_s2_q) begin
      filt_q <= 2'h0;
    end else if (filt_q != RST_FILTER_CNT) begin
      filt_q <= filt_q + 2'h1;
    end
  end
  assign pin_low = (filt_q == RST_FILTER_CNT) && !pin_s2_q;

  // apb decode; zero-wait, unmapped reads zero with slverr
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign wr_ctrl = wr_en && (paddr == REG_CTRL);
  assign wr_cmd = wr_en && (paddr == REG_CMD);
  assign cmd_software_reset_instr = wr_cmd && pwdata[CMD_SOFTWARE_RESET_INSTR] && !in_reset;
  assign cmd_end_of_init_instr = wr_cmd && pwdata[CMD_END_OF_INIT_INSTR] && !in_reset;
  assign cmd_srv = wr_cmd && pwdata[CMD_SERVICE_WATCHDOG_INSTR] && !in_reset;
  assign cmd_dis = wr_cmd && pwdata[CMD_DISABLE_WATCHDOG_INSTR] && !in_reset;
  assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_CMD
                                        || paddr == REG_WDT || paddr == REG_CFG);

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        REG_CTRL: prdata = {30'h0, pllsel_q, bdrst_q};
        REG_STATUS: prdata = {24'h0, adapt_q, ext_q, boot_q, wdt_dis_q, end_of_init_instr_q, watchdog_reset_flag_q, long_hw_reset_flag_q, short_hw_reset_flag_q};
        REG_WDT: prdata = {15'h0, wdt_cnt_q};
        REG_CFG: prdata = {{(32-CFG_W){1'b0}}, cfg_q};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // sources no watchdog reset in boot mode
  assign wdt_ovf = (wdt_cnt_q == 17'(WDT_OVF - 1)) && !wdt_dis_q && !boot_q && !in_reset;
  assign rst_src_hw = pin_low;
  assign rst_src_sw = cmd_software_reset_instr;
  assign rst_src_wdt = wdt_ovf;
  assign any_src = rst_src_hw || rst_src_sw || rst_src_wdt;
  // watchdog reset finishes a bus cycle unless ready was sampled high
  assign bus_done = !bus_cycle_active || (bus_uses_ready && bus_ready_sampled && bus_ready_n);
  assign in_reset = state_q != SRS_RUN;
  assign seq_end = (state_q == SRS_SEQ) && (seq_cnt_q == SEQ_LAST);
  // released once pin high and, with pll clock, pll locked
  assign release_ok = pin_s2_q && (pll_locked || !pllsel_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SRS_RUN: begin
        if (rst_src_wdt && !bus_done) state_d = SRS_BUSWAIT;
        else if (any_src) state_d = SRS_SEQ;
      end
      SRS_BUSWAIT: begin
        if (bus_done || !bus_cycle_active || bus_ready_sampled) state_d = SRS_SEQ;
      end
      SRS_SEQ: begin
        if (seq_end) state_d = release_ok ? SRS_RUN : SRS_HOLD;
      end
      SRS_HOLD: begin
        if (release_ok) state_d = SRS_RUN;
      end
      default: state_d = SRS_SEQ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= SRS_SEQ;
      seq_cnt_q <= '0;
      src_q <= SRC_HW;
      bd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == SRS_RUN && any_src) begin
        src_q <= rst_src_hw ? SRC_HW : (rst_src_wdt ? SRC_WDT : SRC_SW);
        bd_q <= bdrst_q;
      end
      if (state_d == SRS_SEQ && state_q != SRS_SEQ) seq_cnt_q <= '0;
      else if (state_q == SRS_SEQ && !seq_end) seq_cnt_q <= seq_cnt_q + 1'b1;
    end
  end

  // source flags watchdog flag
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      short_hw_reset_flag_q <= 1'b0;
      long_hw_reset_flag_q <= 1'b1;
      watchdog_reset_flag_q <= 1'b0;
    end else begin
      if (seq_end) begin
        short_hw_reset_flag_q <= !bd_q && src_q == SRC_HW && release_ok;
        long_hw_reset_flag_q <= bd_q || (src_q == SRC_HW && !release_ok);
      end
      if (seq_end && src_q == SRC_WDT) watchdog_reset_flag_q <= 1'b1;
      else if (seq_end && src_q == SRC_HW) watchdog_reset_flag_q <= 1'b0;
      else if (cmd_srv || cmd_end_of_init_instr) watchdog_reset_flag_q <= 1'b0;
    end
  end

  // configuration latches stay shut during the sequence; opened at release
  // sw/wdt resets relatch bus fields only on external start unless bidirectional
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg_q <= CFG_RST;
      boot_q <= 1'b0;
      ext_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= !in_reset;
      if (in_reset && state_d == SRS_RUN) begin
        if (src_q == SRC_HW || bd_q || !ext_start_n) begin
          cfg_q <= config_port;
          ext_q <= !ext_start_n;
        end
        if (src_q == SRC_HW || bd_q) begin
          boot_q <= !config_port[4] || !rd_n_pin;
        end
      end
    end
  end

  // adapt mode taken on the pin's rising edge, not at release
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      adapt_q <= 1'b0;
    end else if (pin_s2_q && !pin_s3_q) begin
      adapt_q <= adapt_mode_select;
    end
  end

  // bidirectional enable and end_of_init_instr cleared by every reset, enable locked after end_of_init_instr; pll select kept
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bdrst_q <= 1'b0;
      pllsel_q <= 1'b0;
      end_of_init_instr_q <= 1'b0;
    end else if (in_reset) begin
      bdrst_q <= 1'b0;
      end_of_init_instr_q <= 1'b0;
    end else begin
      if (wr_ctrl && !end_of_init_instr_q) bdrst_q <= pwdata[CTRL_BDRST];
      if (wr_ctrl) pllsel_q <= pwdata[CTRL_PLLSEL];
      if (cmd_end_of_init_instr) end_of_init_instr_q <= 1'b1;
    end
  end

  // watchdog: starts after reset, overflow at 2*2^16 cycles disable window
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wdt_cnt_q <= '0;
      wdt_dis_q <= 1'b0;
      wdt_srv_seen_q <= 1'b0;
    end else if (in_reset) begin
      wdt_cnt_q <= {WDT_RELOAD_RST, 9'h000};
      wdt_dis_q <= 1'b0;
      wdt_srv_seen_q <= 1'b0;
    end else begin
      if (cmd_dis && !wdt_srv_seen_q && !end_of_init_instr_q) wdt_dis_q <= 1'b1;
      if (cmd_srv || cmd_end_of_init_instr) wdt_srv_seen_q <= 1'b1;
      if (cmd_srv) wdt_cnt_q <= '0;
      else if (!wdt_dis_q) wdt_cnt_q <= wdt_cnt_q + 17'h1;
    end
  end

  // outputs
  assign sys_reset = in_reset;
  assign hold_cancel = in_reset;
  // a watchdog reset parked in the bus wait lets the running cycle finish; an abort goes straight to the sequence
  assign bus_abort = (state_q == SRS_SEQ) || (state_q == SRS_HOLD);
  assign pins_tristate = state_q == SRS_SEQ || state_q == SRS_HOLD;
  assign strobes_inactive = strobe_q;
  assign cpu_run = !in_reset;
  assign boot_mode = boot_q;
  assign latched_cfg = cfg_q;
  assign reset_output_pin_n = !in_reset && end_of_init_instr_q;
  assign reset_input_pin_o = 1'b0;
  // drive the open-drain pin only while the sequence itself runs
  assign reset_input_pin_oe_n = !(bd_q && state_q == SRS_SEQ);

  // assertions
  property p_seq_len;
    @(posedge core_clk) disable iff (!resetn)
      $rose(state_q == SRS_SEQ) |-> (state_q == SRS_SEQ)[*8] ##0 (seq_cnt_q == 10'h007);
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("sequence counter not advancing");
  property p_seq_end;
    @(posedge core_clk) disable iff (!resetn)
      seq_end |=> (state_q != SRS_SEQ);
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("sequence did not end at last count");
  property p_hold;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == SRS_HOLD && !release_ok) |=> sys_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("reset released too early");
  property p_reset_output_pin;
    @(posedge core_clk) disable iff (!resetn)
      $fell(reset_output_pin_n) |-> $past(end_of_init_instr_q) && sys_reset;
  endproperty
  a_reset_output_pin: assert property (p_reset_output_pin) else $error("reset output fell outside a reset");
  property p_reset_output_pin_stay;
    @(posedge core_clk) disable iff (!resetn)
      $fell(sys_reset) |-> !reset_output_pin_n;
  endproperty
  a_reset_output_pin_stay: assert property (p_reset_output_pin_stay) else $error("reset output rose before end_of_init_instr");
  property p_bdrst_lock;
    @(posedge core_clk) disable iff (!resetn)
      (end_of_init_instr_q && !in_reset) |=> ($stable(bdrst_q) || in_reset);
  endproperty
  a_bdrst_lock: assert property (p_bdrst_lock) else $error("bidirectional enable changed after end_of_init_instr");
  property p_no_wdt_boot;
    @(posedge core_clk) disable iff (!resetn)
      boot_q |-> !rst_src_wdt;
  endproperty
  a_no_wdt_boot: assert property (p_no_wdt_boot) else $error("watchdog reset in boot mode");
  property p_od;
    @(posedge core_clk) disable iff (!resetn)
      !reset_input_pin_oe_n |-> (state_q == SRS_SEQ) && !reset_input_pin_o;
  endproperty
  a_od: assert property (p_od) else $error("reset pin driven outside sequence");
  property p_cfg_closed;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == SRS_SEQ && !seq_end) |=> $stable(cfg_q);
  endproperty
  a_cfg_closed: assert property (p_cfg_closed) else $error("config latch open during sequence");
  property p_seq_start;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == SRS_RUN && any_src && bus_done) |=> (state_q == SRS_SEQ) && (seq_cnt_q == 10'h000);
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("reset source did not start the sequence");
  property p_seq_outputs;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == SRS_SEQ) |-> bus_abort && pins_tristate && hold_cancel && !cpu_run;
  endproperty
  a_seq_outputs: assert property (p_seq_outputs) else $error("bus or pins active during sequence");
  property p_wdt_bus_wait;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == SRS_BUSWAIT) |-> !bus_abort && !pins_tristate;
  endproperty
  a_wdt_bus_wait: assert property (p_wdt_bus_wait) else $error("bus cycle aborted while waiting");
  property p_hold_release;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == SRS_HOLD && release_ok) |=> !sys_reset;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("reset held after release");
  property p_cfg_latch;
    @(posedge core_clk) disable iff (!resetn)
      (in_reset && state_d == SRS_RUN && (src_q == SRC_HW || bd_q)) |=> (latched_cfg == $past(config_port));
  endproperty
  a_cfg_latch: assert property (p_cfg_latch) else $error("config not latched at release");
  property p_strobe_order;
    @(posedge core_clk) disable iff (!resetn)
      $fell(sys_reset) |-> !strobes_inactive ##1 strobes_inactive;
  endproperty
  a_strobe_order: assert property (p_strobe_order) else $error("strobes not driven after config latch");
  property p_short_flag;
    @(posedge core_clk) disable iff (!resetn)
      (seq_end && release_ok && src_q == SRC_HW && !bd_q) |=> short_hw_reset_flag_q && !long_hw_reset_flag_q;
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short reset not recorded");
  property p_bidir_long;
    @(posedge core_clk) disable iff (!resetn)
      (seq_end && bd_q) |=> long_hw_reset_flag_q && !short_hw_reset_flag_q;
  endproperty
  a_bidir_long: assert property (p_bidir_long) else $error("bidirectional reset not recorded as long");
  property p_watchdog_reset_flag_set;
    @(posedge core_clk) disable iff (!resetn)
      (seq_end && src_q == SRC_WDT) |=> watchdog_reset_flag_q;
  endproperty
  a_watchdog_reset_flag_set: assert property (p_watchdog_reset_flag_set) else $error("watchdog flag not set");
  property p_dis_window;
    @(posedge core_clk) disable iff (!resetn)
      (!in_reset && !wdt_dis_q && (wdt_srv_seen_q || end_of_init_instr_q)) |=> !wdt_dis_q;
  endproperty
  a_dis_window: assert property (p_dis_window) else $error("watchdog disabled after window closed");
endmodule

// >>> verif/srs_reset_partner.sv
// partner model: external open-drain reset circuitry with pull-up on the reset pin
module srs_reset_partner #(
  parameter int unsigned POR_CYCLES = 1036,
  parameter int unsigned MIN_LOW = 4
) (
  // clock
  input wire logic core_clk,
  // pull-low request from the bench, device driver enable
  input wire logic ext_low,
  input wire logic dev_oe_n,
  // resolved pin level
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned hold_q = POR_CYCLES;
  always @(posedge core_clk) begin
    if (hold_q != 0) begin
      hold_q <= hold_q - 1;
    end else if (ext_low) begin
      hold_q <= MIN_LOW;
    end
  end
  // wired-and of both open drains; the pull-up wins only when nobody pulls low
  assign pin = (hold_q != 0 || ext_low || !dev_oe_n) ? 1'b0 : 1'b1;
endmodule

// >>> verif/tb.sv
// testbench for the system reset sequencer
module tb;
  import srs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] FM = 32'h00000007;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd_v;
  logic pready, pslverr, er_v, pin, pin_o, oe_n, rst_out_n, ext_low = 1'b0;
  logic [CFG_W-1:0] config_port = 16'h1234;
  logic rd_n_pin = 1'b1, ale_pin = 1'b0, ext_start_n = 1'b1, adapt = 1'b0, pll_locked = 1'b1;
  logic bus_act = 1'b0, bus_rdy_use = 1'b0, bus_rdy_smp = 1'b0, bus_ready_n = 1'b1;
  logic sys_reset, hold_cancel, bus_abort, pins_tristate, strobes_inactive, cpu_run, boot_mode;
  logic [CFG_W-1:0] latched_cfg;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int w, n;
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  srs_reset_partner srs_reset_partner_inst (.core_clk(core_clk), .ext_low(ext_low), .dev_oe_n(oe_n), .pin(pin));
  srs_system_reset_sequencer #(.WDT_OVF(2000)) srs_system_reset_sequencer_inst (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_input_pin_i(pin),
    .reset_input_pin_o(pin_o), .reset_input_pin_oe_n(oe_n), .reset_output_pin_n(rst_out_n),
    .config_port(config_port), .rd_n_pin(rd_n_pin), .ale_pin(ale_pin), .ext_start_n(ext_start_n),
    .adapt_mode_select(adapt), .pll_locked(pll_locked), .bus_cycle_active(bus_act),
    .bus_uses_ready(bus_rdy_use), .bus_ready_sampled(bus_rdy_smp), .bus_ready_n(bus_ready_n),
    .sys_reset(sys_reset), .hold_cancel(hold_cancel), .bus_abort(bus_abort), .pins_tristate(pins_tristate),
    .strobes_inactive(strobes_inactive), .cpu_run(cpu_run), .boot_mode(boot_mode), .latched_cfg(latched_cfg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("mismatches=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer; the request stands until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd_v & m, e);
  endtask
  // w: cycles until reset rises (3000 if never), n: cycles it stays high
  task automatic seq_len(output int w, output int n);
    w = 0;
    n = 0;
    while (sys_reset !== 1'b1 && w < 3000) begin
      @(posedge core_clk);
      w++;
    end
    while (sys_reset === 1'b1 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic pin_low(input int c);
    ext_low <= 1'b1;
    repeat (c) @(posedge core_clk);
    ext_low <= 1'b0;
  endtask
  task automatic s_por;
    seq_len(w, n);
    st(FM, 32'h2);
    chk(rst_out_n, 1'b0);
  endtask
  task automatic s_short;
    adapt <= 1'b1;
    fork
      seq_len(w, n);
      begin
        pin_low(1);
        repeat (200) @(posedge core_clk);
        chk({pins_tristate, hold_cancel, bus_abort, cpu_run}, 32'hE);
        config_port <= 16'hA5B5;
        adapt <= 1'b0;
      end
    join
    chk(n, 516);
    // strobes follow the config latch by one clock
    @(posedge core_clk);
    chk(latched_cfg, 16'hA5B5);
    chk(strobes_inactive & cpu_run, 1'b1);
    st(FM, 32'h1);
    st(32'h80, 32'h80);
  endtask
  task automatic s_long;
    fork
      seq_len(w, n);
      pin_low(700);
    join
    chk(32'(n > 600), 1);
    st(FM, 32'h2);
    apb(1'b1, REG_CTRL, 32'h2);
    pll_locked <= 1'b0;
    apb(1'b1, REG_CMD, 32'h1);
    fork
      seq_len(w, n);
      begin
        repeat (800) @(posedge core_clk);
        pll_locked <= 1'b1;
      end
    join
    chk(32'(n > 700), 1);
    apb(1'b1, REG_CTRL, 32'h0);
  endtask
  task automatic s_sw;
    ext_start_n <= 1'b0;
    config_port <= 16'h00F0;
    apb(1'b1, REG_CMD, 32'h1);
    fork
      seq_len(w, n);
      begin
        repeat (100) @(posedge core_clk);
        pin_low(1);
      end
    join
    chk(n, 516);
    chk(latched_cfg, 16'h00F0);
    ext_start_n <= 1'b1;
    config_port <= 16'h0F10;
    apb(1'b1, REG_CMD, 32'h1);
    seq_len(w, n);
    chk(latched_cfg, 16'h00F0);
  endtask
  task automatic s_wdt;
    ext_start_n <= 1'b0;
    config_port <= 16'h0C3C;
    bus_act <= 1'b1;
    bus_rdy_use <= 1'b1;
    fork
      seq_len(w, n);
      begin
        wait (sys_reset === 1'b1);
        repeat (3) @(posedge core_clk);
        chk({pins_tristate, bus_abort}, 32'h0);
        bus_rdy_smp <= 1'b1;
        bus_ready_n <= 1'b0;
        @(posedge core_clk);
        bus_act <= 1'b0;
        bus_rdy_smp <= 1'b0;
        bus_ready_n <= 1'b1;
      end
    join
    chk(32'(w >= 1990 && w <= 2010), 1);
    chk(n, 520);
    chk(latched_cfg, 16'h0C3C);
    st(FM, 32'h4);
    apb(1'b1, REG_CMD, 32'h4);
    st(FM, 32'h0);
    apb(1'b1, REG_CMD, 32'h8);
    seq_len(w, n);
    chk(32'(w < 2100), 1);
    apb(1'b1, REG_CMD, 32'h8);
    st(32'h10, 32'h10);
    seq_len(w, n);
    chk(n, 0);
  endtask
  task automatic s_bidir;
    apb(1'b1, REG_CTRL, 32'h1);
    config_port <= 16'h0000;
    apb(1'b1, REG_CMD, 32'h1);
    fork
      seq_len(w, n);
      begin
        repeat (100) @(posedge core_clk);
        chk(oe_n, 1'b0);
      end
    join
    chk(oe_n, 1'b1);
    // the watchdog flag from the last overflow survives the software reset
    st(FM, 32'h6);
    chk(boot_mode, 1'b1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd_v & 32'h1, 32'h0);
    seq_len(w, n);
    chk(n, 0);
    apb(1'b1, REG_CTRL, 32'h1);
    pin_low(1);
    seq_len(w, n);
    chk(32'(n >= 516), 1);
    st(FM, 32'h2);
    apb(1'b1, REG_CMD, 32'h2);
    @(posedge core_clk);
    chk(rst_out_n, 1'b1);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd_v & 32'h1, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd_v[30:0], er_v}, 32'h1);
  endtask
  // a hang ends the run through the same closing report
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    s_por();
    s_short();
    s_long();
    s_sw();
    s_wdt();
    s_bidir();
    results();
  end
endmodule
